// ### common/pmcrb_map.svh
// register pointers, field positions, reset values of the control register bank
`ifndef PMCRB_MAP_SVH
`define PMCRB_MAP_SVH
`define PMCRB_PTR_MASK_CHG      8'h03
`define PMCRB_PTR_MASK_SYS      8'h04
`define PMCRB_PTR_ENABLE        8'h05
`define PMCRB_PTR_LIN_FIRST     8'h06
`define PMCRB_PTR_LIN_SECOND    8'h07
`define PMCRB_PTR_STEP_UP       8'h08
`define PMCRB_PTR_CHG_CTRL      8'h09
`define PMCRB_RST_MASK_CHG      8'hFF
`define PMCRB_RST_MASK_SYS      8'hEF
`define PMCRB_RST_ENABLE        8'h80
`define PMCRB_RST_LIN_FIRST     8'h1C
`define PMCRB_RST_LIN_SECOND    8'hBB
`define PMCRB_RST_STEP_UP       8'h0F
`define PMCRB_RST_CHG_CTRL      8'h1F
`define PMCRB_STEP_UP_USED_MASK 8'h0F
`define PMCRB_BIT_WATCHDOG_EN   6
`define PMCRB_BIT_CHARGER_EN    0
`define PMCRB_BIT_CHARGER_DET   6
`endif

// ### common/pmcrb_pkg.sv
// types shared by the control register bank
package pmcrb_pkg;
    // one register access from the serial bus front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] ptr;
        logic [7:0] data;
    } pmcrb_access_type;

    // decoded supply enables
    typedef struct packed {
        logic indicator_led_enable;
        logic charge_watchdog_enable;
        logic step_up_two_enable;
        logic step_up_one_enable;
        logic linear_four_enable;
        logic linear_three_enable;
        logic linear_two_enable;
        logic linear_one_enable;
    } pmcrb_enables_type;

    // voltage and charger settings
    typedef struct packed {
        logic [3:0] linear_one_code;
        logic [3:0] linear_two_code;
        logic [3:0] linear_three_code;
        logic [3:0] linear_four_code;
        logic [3:0] step_up_one_code;
        logic       charger_enable;
        logic [1:0] top_off_threshold;
    } pmcrb_settings_type;

    typedef enum logic [1:0] {
        PMCRB_POWER_UP,
        PMCRB_RUN
    } pmcrb_irq_state_type;
endpackage

// ### hdl/pmcrb_bank.sv
// control register bank: masks, event latching, supply enables and voltage codes
//
// Functional notes
// - charger mask write-only at 0x03, resets 0xFF
// - system mask write-only at 0x04, resets 0xEF
// - charger mask bits follow charger event sources
// - system mask bits follow system event sources
// - system mask bit 6 gates charger detect
// - enable register 0x05 resets 0x80
// - enable bit 6 switches charge watchdog
// - 0x06 low nibble linear one, reset 0x1C
// - 0x06 high nibble linear two, code 0001
// - 0x07 holds linear three/four, reset 0xBB
// - 0x08 step-up code, reset 0x0F
// - 0x09 bit 0 enables charger, default on
// - 0x09 bits 2:1 top-off threshold, reset 11
// - interrupt asserts for unmasked set events
// - reads clear events, late events held
// - interrupt held off until first event read
`include "pmcrb_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pmcrb_bank
    import pmcrb_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire pmcrb_access_type  access_in,
    input  wire logic [7:0]        charger_event_in,
    input  wire logic [7:0]        system_event_in,
    input  wire logic              power_on_comparator_out_in,
    output logic [7:0]             read_data_out,
    output logic                   irq_n_out,
    output pmcrb_enables_type      enables_out,
    output pmcrb_settings_type     settings_out
);
    logic [7:0]          mask_charger_reg;
    logic [7:0]          mask_system_reg;
    logic [7:0]          enable_reg;
    logic [7:0]          lin_first_reg;
    logic [7:0]          lin_second_reg;
    logic [7:0]          step_up_reg;
    logic [7:0]          chg_ctrl_reg;
    logic [7:0]          event_charger_reg;
    logic [7:0]          event_system_reg;
    logic [7:0]          pend_charger_reg;
    logic [7:0]          pend_system_reg;
    logic [7:0]          read_data_reg;
    logic                irq_n_reg;
    pmcrb_irq_state_type irq_state_reg;
    logic [7:0]          system_src;
    logic                rd_charger;
    logic                rd_system;
    logic                wr_hit;

    // write strobe matched against one pointer
    function automatic logic pmcrb_wr_hit(input pmcrb_access_type acc, input logic [7:0] ptr);
        pmcrb_wr_hit = acc.wr && (acc.ptr == ptr);
    endfunction

    // read strobes on the event pointers, shared with the masks
    assign rd_charger = access_in.rd && (access_in.ptr == `PMCRB_PTR_MASK_CHG);
    assign rd_system  = access_in.rd && (access_in.ptr == `PMCRB_PTR_MASK_SYS);
    assign wr_hit     = access_in.wr;

    // charger detect only counts when the power-on comparator confirms it
    always_comb begin
        system_src = system_event_in;
        system_src[`PMCRB_BIT_CHARGER_DET] = system_event_in[`PMCRB_BIT_CHARGER_DET]
                                             & power_on_comparator_out_in;
    end

    // write-only masks; reads never touch them
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_charger_reg <= `PMCRB_RST_MASK_CHG;
            mask_system_reg  <= `PMCRB_RST_MASK_SYS;
        end else begin
            if (pmcrb_wr_hit(access_in, `PMCRB_PTR_MASK_CHG)) begin
                mask_charger_reg <= access_in.data;
            end
            if (pmcrb_wr_hit(access_in, `PMCRB_PTR_MASK_SYS)) begin
                mask_system_reg <= access_in.data;
            end
        end
    end

    // read/write control registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_reg     <= `PMCRB_RST_ENABLE;
            lin_first_reg  <= `PMCRB_RST_LIN_FIRST;
            lin_second_reg <= `PMCRB_RST_LIN_SECOND;
            step_up_reg    <= `PMCRB_RST_STEP_UP;
            chg_ctrl_reg   <= `PMCRB_RST_CHG_CTRL;
        end else if (wr_hit) begin
            case (access_in.ptr)
                `PMCRB_PTR_ENABLE:     enable_reg     <= access_in.data;
                `PMCRB_PTR_LIN_FIRST:  lin_first_reg  <= access_in.data;
                `PMCRB_PTR_LIN_SECOND: lin_second_reg <= access_in.data;
                // reserved bits dropped on write
                `PMCRB_PTR_STEP_UP:    step_up_reg    <= access_in.data & `PMCRB_STEP_UP_USED_MASK;
                `PMCRB_PTR_CHG_CTRL:   chg_ctrl_reg   <= access_in.data;
                default: begin
                end
            endcase
        end
    end

    // event latching: a read clears, sources arriving meanwhile go to pending
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            event_charger_reg <= 8'h00;
            event_system_reg  <= 8'h00;
            pend_charger_reg  <= 8'h00;
            pend_system_reg   <= 8'h00;
        end else begin
            if (rd_charger) begin
                event_charger_reg <= 8'h00;
                pend_charger_reg  <= pend_charger_reg | charger_event_in;
            end else begin
                event_charger_reg <= event_charger_reg | pend_charger_reg | charger_event_in;
                pend_charger_reg  <= 8'h00;
            end
            if (rd_system) begin
                event_system_reg <= 8'h00;
                pend_system_reg  <= pend_system_reg | system_src;
            end else begin
                event_system_reg <= event_system_reg | pend_system_reg | system_src;
                pend_system_reg  <= 8'h00;
            end
        end
    end

    // interrupt stays off after power-up until events are first read
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_state_reg <= PMCRB_POWER_UP;
        end else begin
            case (irq_state_reg)
                PMCRB_POWER_UP: if (rd_charger || rd_system) irq_state_reg <= PMCRB_RUN;
                PMCRB_RUN:      irq_state_reg <= PMCRB_RUN;
                default:        irq_state_reg <= PMCRB_POWER_UP;
            endcase
        end
    end

    // active-low interrupt from unmasked latched events
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_n_reg <= 1'b1;
        end else begin
            irq_n_reg <= !((irq_state_reg == PMCRB_RUN) &&
                          (|(event_charger_reg & ~mask_charger_reg) ||
                           |(event_system_reg & ~mask_system_reg)));
        end
    end

    // registered read data; mask pointers return events
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_data_reg <= 8'h00;
        end else if (access_in.rd) begin
            case (access_in.ptr)
                `PMCRB_PTR_MASK_CHG:   read_data_reg <= event_charger_reg;
                `PMCRB_PTR_MASK_SYS:   read_data_reg <= event_system_reg;
                `PMCRB_PTR_ENABLE:     read_data_reg <= enable_reg;
                `PMCRB_PTR_LIN_FIRST:  read_data_reg <= lin_first_reg;
                `PMCRB_PTR_LIN_SECOND: read_data_reg <= lin_second_reg;
                `PMCRB_PTR_STEP_UP:    read_data_reg <= step_up_reg & `PMCRB_STEP_UP_USED_MASK;
                `PMCRB_PTR_CHG_CTRL:   read_data_reg <= chg_ctrl_reg;
                default:               read_data_reg <= 8'h00;
            endcase
        end
    end

    assign read_data_out = read_data_reg;
    assign irq_n_out     = irq_n_reg;

    // decoded controls toward the analog blocks
    assign enables_out = pmcrb_enables_type'(enable_reg);
    always_comb begin
        settings_out.linear_one_code   = lin_first_reg[3:0];
        settings_out.linear_two_code   = lin_first_reg[7:4];
        settings_out.linear_three_code = lin_second_reg[3:0];
        settings_out.linear_four_code  = lin_second_reg[7:4];
        settings_out.step_up_one_code  = step_up_reg[3:0];
        settings_out.charger_enable    = chg_ctrl_reg[`PMCRB_BIT_CHARGER_EN];
        settings_out.top_off_threshold = chg_ctrl_reg[2:1];
    end
endmodule
`default_nettype wire

// ### verif/pmcrb_properties.sv
// assertion checker for the control register bank
`timescale 1ns/1ps
`default_nettype none
module pmcrb_properties
    import pmcrb_pkg::*;
(
    input wire logic               clk_in,
    input wire logic               rst_n_in,
    input wire pmcrb_access_type   access_in,
    input wire logic [7:0]         read_data_out,
    input wire logic               irq_n_out,
    input wire pmcrb_enables_type  enables_out,
    input wire pmcrb_settings_type settings_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic rd_seen_reg;
    // first event read ends the power-up hold; cleared by every reset
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) rd_seen_reg <= 1'b0;
        else if (access_in.rd && access_in.ptr inside {8'h03, 8'h04}) rd_seen_reg <= 1'b1;
    end
    AST_ENABLE_WRITE: assert property (access_in.wr && access_in.ptr == 8'h05
        |=> enables_out == $past(access_in.data)) else $error("enable write lost");
    AST_WATCHDOG_WRITE: assert property (access_in.wr && access_in.ptr == 8'h05
        |=> enables_out.charge_watchdog_enable == $past(access_in.data[6])) else $error("watchdog bit wrong");
    // low nibble is regulator one, high nibble regulator two
    AST_LIN_FIRST_WRITE: assert property (access_in.wr && access_in.ptr == 8'h06
        |=> {settings_out.linear_two_code, settings_out.linear_one_code} == $past(access_in.data))
        else $error("linear pair one wrong");
    AST_LIN_SECOND_WRITE: assert property (access_in.wr && access_in.ptr == 8'h07
        |=> {settings_out.linear_four_code, settings_out.linear_three_code} == $past(access_in.data))
        else $error("linear pair two wrong");
    AST_STEP_UP_WRITE: assert property (access_in.wr && access_in.ptr == 8'h08
        |=> settings_out.step_up_one_code == $past(access_in.data[3:0])) else $error("step-up code wrong");
    // bit 0 is the charger enable, bits 2:1 the top-off code
    AST_CHARGER_WRITE: assert property (access_in.wr && access_in.ptr == 8'h09
        |=> {settings_out.top_off_threshold, settings_out.charger_enable} == $past(access_in.data[2:0]))
        else $error("charger fields wrong");
    AST_STEP_UP_RSVD_ZERO: assert property (access_in.rd && access_in.ptr == 8'h08
        |=> read_data_out[7:4] == 4'h0) else $error("reserved bits not zero");
    AST_READ_DATA_HOLDS: assert property (!access_in.rd |=> $stable(read_data_out))
        else $error("read data moved without read");
    AST_IRQ_HELD_POWER_UP: assert property (!irq_n_out |-> rd_seen_reg)
        else $error("interrupt before first event read");
    cover property (access_in.wr && access_in.ptr == 8'h03);
    cover property (access_in.rd && access_in.ptr == 8'h04 ##1 read_data_out != 8'h00);
    cover property (!irq_n_out);
endmodule
bind pmcrb_bank pmcrb_properties chk (.clk_in, .rst_n_in, .access_in, .read_data_out, .irq_n_out,
    .enables_out, .settings_out);
`default_nettype wire

// ### verif/pmcrb_host_model.sv
// host model issuing single-byte register accesses
`timescale 1ns/1ps
`default_nettype none
module pmcrb_host_model
    import pmcrb_pkg::*;
(
    input  wire logic            clk_in,
    input  wire logic [7:0]      read_data_in,
    output var pmcrb_access_type access_out
);
    initial access_out = '0;
    // strobe stands one edge only; data taken once the answer has settled
    task automatic xfer(input logic w, input logic [7:0] p, d, output logic [7:0] q);
        @(posedge clk_in);
        access_out <= '{w, ~w, p, d};
        @(posedge clk_in);
        access_out <= '0;
        @(posedge clk_in);
        #1 q = read_data_in;
    endtask
endmodule
`default_nettype wire

// ### verif/pmcrb_bank_test.sv
// self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module pmcrb_bank_test;
    import pmcrb_pkg::*;
    logic               clk_in = 1'b0;
    logic               rst_n_in = 1'b0;
    logic               cmp = 1'b0;
    logic [7:0]         chg_ev = 8'h00, sys_ev = 8'h00, rdata, q;
    logic               irq_n;
    pmcrb_access_type   acc;
    pmcrb_enables_type  en;
    pmcrb_settings_type st;
    int                 errors = 0, total_checks = 0, cycles = 0;
    // pointer, write data, expected read back
    localparam logic [23:0] ROWS [6] = '{24'h055A5A, 24'h06A5A5, 24'h073C3C, 24'h08FF0F, 24'h0A5500,
        24'h054040};
    always #20 clk_in = ~clk_in;
    pmcrb_host_model host (.clk_in(clk_in), .read_data_in(rdata), .access_out(acc));
    pmcrb_bank uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .access_in(acc), .charger_event_in(chg_ev),
        .system_event_in(sys_ev), .power_on_comparator_out_in(cmp), .read_data_out(rdata),
        .irq_n_out(irq_n), .enables_out(en), .settings_out(st));
    task automatic check(input logic [7:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle event pulse, then room for latch and interrupt
    task automatic pulse(input logic [7:0] c, s);
        @(posedge clk_in);
        chg_ev <= c;
        sys_ev <= s;
        @(posedge clk_in);
        chg_ev <= 8'h00;
        sys_ev <= 8'h00;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task automatic rd_check(input logic [7:0] p, exp);
        host.xfer(1'b0, p, 8'h00, q);
        check(q, exp);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // hang guard, far above the run length
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge clk_in);
        #1;
        check(en, 8'h80);
        check(st[22:15], 8'hC1);
        check(st[14:7], 8'hBB);
        check({1'b0, st[6:0]}, 8'h7F);
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (ROWS[i]) begin
            host.xfer(1'b1, ROWS[i][23:16], ROWS[i][15:8], q);
            rd_check(ROWS[i][23:16], ROWS[i][7:0]);
        end
        check(en, 8'h40);
        host.xfer(1'b1, 8'h09, 8'h02, q);
        check({1'b0, st[6:0]}, 8'h79);
        // unmasked source, but still held until the first event read
        pulse(8'h01, 8'h10);
        check({7'h00, irq_n}, 8'h01);
        rd_check(8'h04, 8'h10);
        rd_check(8'h03, 8'h01);
        rd_check(8'h03, 8'h00);
        pulse(8'h01, 8'h10);
        check({7'h00, irq_n}, 8'h00);
        rd_check(8'h04, 8'h10);
        check({7'h00, irq_n}, 8'h01);
        rd_check(8'h03, 8'h01);
        host.xfer(1'b1, 8'h03, 8'hFE, q);
        pulse(8'h01, 8'h00);
        check({7'h00, irq_n}, 8'h00);
        rd_check(8'h03, 8'h01);
        pulse(8'h00, 8'h40);
        rd_check(8'h04, 8'h00);
        @(posedge clk_in);
        cmp <= 1'b1;
        pulse(8'h00, 8'h40);
        rd_check(8'h04, 8'h40);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        @(posedge clk_in);
        #1;
        check(en, 8'h80);
        tally_and_finish();
    end
endmodule
`default_nettype wire
